/* mcc_config.sv */
// The Wishbone slave port was decided locally.
`include "mcc_map.svh"

// Notes on behaviour
// R1: Configuration register resets to all zeros
// R2: Host writes only while transmit is idle
// R3: Cipher bypass acts in TP-PMD only
// R4: Bit 1 selects full duplex, else half
// R5: Padding extends short frames, forces CRC
// R6: CRC append bit, ignored while padding
// R7: Retry late collisions past 512 bit times
// R8: Oversize bit allows frames over 1518
// R9: Jabber: 20 ms on aborts, 250 ms block
// R10: Host sets fast clock bit above 25 MHz
// R11: Mode field selects MII, TP-PMD, 10BASE-T
// R12: Loopback point depends on interface mode
// R13: Loopback works in half and full duplex
// R14: Soft reset held while bit 15 is one
// R15: Full duplex ignores carrier and collision
// R16: Half duplex without loopback disables receive during transmit
// R17: Reserved and soft reset bits read zero
// R18: Reserved mode enables no interface path
module mcc_config #(
    parameter int unsigned JAB_ON_CYC    = `MCC_JAB_ON_CYC,
    parameter int unsigned JAB_OFF_CYC   = `MCC_JAB_OFF_CYC,
    parameter int unsigned LATE_FAST_CYC = `MCC_LATE_FAST_CYC,
    parameter int unsigned LATE_SLOW_CYC = `MCC_LATE_SLOW_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Datapath status
    input  wire logic        txEnReq,
    input  wire logic        txActive,
    input  wire logic        txByteStb,
    input  wire logic        txLastByte,
    input  wire logic        rxActive,
    input  wire logic        rxByteStb,
    input  wire logic        crsIn,
    input  wire logic        colIn,
    // Controls and events
    output mcc_pkg::mcc_ctl_s ctlOut,
    output logic             transmitEnableOut,
    output logic             rxEnableOut,
    output logic             deferTx,
    output logic             colSeen,
    output logic             jabberAbort,
    output logic             lateRetryReq,
    output logic             lateAbort,
    output logic             padReq,
    output logic [1:0]       lenErr
);

    localparam int JMAX = (JAB_ON_CYC > JAB_OFF_CYC) ? JAB_ON_CYC : JAB_OFF_CYC;
    localparam int JW   = $clog2(JMAX + 1);
    localparam int LW   = $clog2(LATE_SLOW_CYC + 1);

    // Register file
    logic [15:0] cfgQ, cfgD;
    logic        ackQ, ackD;
    logic [31:0] datQ, datD;
    logic        softRst;
    logic [1:0]  modeV;
    logic        isMii, isTp, is10;

    assign softRst = cfgQ[`MCC_BIT_SOFT_RESET];
    assign modeV   = cfgQ[`MCC_BIT_MODE_HI:`MCC_BIT_MODE_LO];
    assign isMii   = modeV == `MCC_MODE_MII;
    assign isTp    = modeV == `MCC_MODE_TP_PMD;
    assign is10    = modeV == `MCC_MODE_10BASE_T;

    mcc_pkg::mcc_jab_e jabQ, jabD;
    logic              txEnQ, txEnD;

    always_comb begin
        cfgD = cfgQ;
        ackD = wb_cyc_i && wb_stb_i && !ackQ;
        datD = 32'h0000_0000;
        if (ackD && wb_we_i) begin
            if (wb_adr_i == `MCC_ADR_CFG) begin
                if (wb_sel_i[0]) begin
                    cfgD[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    cfgD[10:8] = wb_dat_i[10:8];
                    cfgD[`MCC_BIT_SOFT_RESET] = wb_dat_i[`MCC_BIT_SOFT_RESET]; // R14
                end
            end
        end else if (ackD) begin
            if (wb_adr_i == `MCC_ADR_CFG) begin
                datD[10:0] = cfgQ[10:0]; // R17
            end else if (wb_adr_i == `MCC_ADR_STATUS) begin
                datD[`MCC_ST_JAB_BLOCK] = jabQ == mcc_pkg::JAB_BLOCK;
                datD[`MCC_ST_JAB_RUN]   = jabQ == mcc_pkg::JAB_RUN;
                datD[`MCC_ST_TX_ENABLE] = txEnQ;
                datD[`MCC_ST_MODE_OK]   = modeV != 2'h3;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfgQ <= `MCC_CFG_RESET; // R1
            ackQ <= 1'b0;
            datQ <= 32'h0000_0000;
        end else begin
            cfgQ <= cfgD;
            ackQ <= ackD;
            datQ <= datD;
        end
    end

    assign wb_ack_o = ackQ;
    assign wb_dat_o = datQ;

    // Decoded controls
    mcc_pkg::mcc_ctl_s ctlQ, ctlD;
    logic              fd, lb, rxEnQ, rxEnD, deferQ, deferD, colQ, colD;

    assign fd = cfgQ[`MCC_BIT_FULL_DUPLEX];
    assign lb = cfgQ[`MCC_BIT_LOOPBACK];

    always_comb begin
        ctlD.cipherBypass        = cfgQ[`MCC_BIT_CIPHER_BYPASS] && isTp; // R3
        ctlD.fullDuplexSel       = fd; // R4
        ctlD.padShortPackets     = cfgQ[`MCC_BIT_PAD_SHORT]; // R5
        ctlD.appendCrc           = cfgQ[`MCC_BIT_APPEND_CRC] || cfgQ[`MCC_BIT_PAD_SHORT]; // R6
        ctlD.lateCollisionRetry  = cfgQ[`MCC_BIT_LATE_RETRY];
        ctlD.oversizePacketAllow = cfgQ[`MCC_BIT_OVERSIZE]; // R8
        ctlD.fastHostClock       = cfgQ[`MCC_BIT_FAST_HOST_CLK] && isMii; // R10
        ctlD.selMii              = isMii; // R11 R18
        ctlD.selTpPmd            = isTp; // R11 R18
        ctlD.sel10BaseT          = is10; // R11 R18
        ctlD.loopSerdes          = lb && is10; // R12
        ctlD.loopCoder           = lb && isTp; // R12
        ctlD.loopMii             = lb && isMii; // R12
        ctlD.softResetCtl        = softRst; // R14
        rxEnD  = !softRst && (fd || lb || !txActive); // R16 R13
        deferD = !fd && crsIn && !softRst; // R15
        colD   = !fd && colIn && txActive && !softRst; // R15
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctlQ   <= '0;
            rxEnQ  <= 1'b0;
            deferQ <= 1'b0;
            colQ   <= 1'b0;
        end else begin
            ctlQ   <= ctlD;
            rxEnQ  <= rxEnD;
            deferQ <= deferD;
            colQ   <= colD;
        end
    end

    assign ctlOut      = ctlQ;
    assign rxEnableOut = rxEnQ;
    assign deferTx     = deferQ;
    assign colSeen     = colQ;

    // Jabber guard
    logic [JW-1:0] jabCntQ, jabCntD;
    logic          jabArm, abortQ, abortD;

    assign jabArm = cfgQ[`MCC_BIT_JABBER_GUARD] && is10;

    always_comb begin
        jabD    = jabQ;
        jabCntD = jabCntQ;
        abortD  = 1'b0;
        case (jabQ)
            mcc_pkg::JAB_IDLE: begin
                jabCntD = '0;
                if (jabArm && txEnReq) begin
                    jabD    = mcc_pkg::JAB_RUN;
                    jabCntD = JW'(1);
                end
            end
            mcc_pkg::JAB_RUN: begin
                if (!jabArm || !txEnReq) begin
                    jabD    = mcc_pkg::JAB_IDLE;
                    jabCntD = '0;
                end else if (jabCntQ == JW'(JAB_ON_CYC - 1)) begin
                    jabD    = mcc_pkg::JAB_BLOCK; // R9
                    jabCntD = '0;
                    abortD  = 1'b1;
                end else begin
                    jabCntD = jabCntQ + JW'(1);
                end
            end
            mcc_pkg::JAB_BLOCK: begin
                if (jabCntQ == JW'(JAB_OFF_CYC - 1)) begin
                    jabD    = mcc_pkg::JAB_IDLE;
                    jabCntD = '0;
                end else begin
                    jabCntD = jabCntQ + JW'(1);
                end
            end
            default: begin
                jabD    = mcc_pkg::JAB_IDLE;
                jabCntD = '0;
            end
        endcase
        if (softRst) begin
            jabD    = mcc_pkg::JAB_IDLE;
            jabCntD = '0;
            abortD  = 1'b0;
        end
        txEnD = txEnReq && !softRst && jabD != mcc_pkg::JAB_BLOCK; // R9
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            jabQ    <= mcc_pkg::JAB_IDLE;
            jabCntQ <= '0;
            abortQ  <= 1'b0;
            txEnQ   <= 1'b0;
        end else begin
            jabQ    <= jabD;
            jabCntQ <= jabCntD;
            abortQ  <= abortD;
            txEnQ   <= txEnD;
        end
    end

    assign transmitEnableOut = txEnQ;
    assign jabberAbort       = abortQ;

    // Late collision timing
    logic [LW-1:0] elapsedQ, elapsedD;
    logic          lateCol, retryQ, retryD, lateAbQ, lateAbD;

    always_comb begin
        elapsedD = elapsedQ;
        if (!txActive || softRst) begin
            elapsedD = '0;
        end else if (elapsedQ != LW'(LATE_SLOW_CYC)) begin
            elapsedD = elapsedQ + LW'(1);
        end
        lateCol = colD && (elapsedQ >= (is10 ? LW'(LATE_SLOW_CYC) : LW'(LATE_FAST_CYC))); // R7
        retryD  = lateCol && cfgQ[`MCC_BIT_LATE_RETRY]; // R7
        lateAbD = lateCol && !cfgQ[`MCC_BIT_LATE_RETRY];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            elapsedQ <= '0;
            retryQ   <= 1'b0;
            lateAbQ  <= 1'b0;
        end else begin
            elapsedQ <= elapsedD;
            retryQ   <= retryD;
            lateAbQ  <= lateAbD;
        end
    end

    assign lateRetryReq = retryQ;
    assign lateAbort    = lateAbQ;

    // Frame length, index 0 transmit and 1 receive
    logic [1:0] lenAct, lenStb;

    assign lenAct = {rxActive && rxEnQ, txActive};
    assign lenStb = {rxByteStb, txByteStb};

    for (genvar i = 0; i < 2; i++) begin : g_len
        logic [10:0] cntQ, cntD;
        logic        errQ, errD;

        always_comb begin
            cntD = cntQ;
            errD = 1'b0;
            if (!lenAct[i] || softRst) begin
                cntD = '0;
            end else if (lenStb[i]) begin
                if (cntQ != 11'h7ff) begin
                    cntD = cntQ + 11'h001;
                end
                errD = cntQ >= 11'(`MCC_MAX_FRAME_BYTES) && !cfgQ[`MCC_BIT_OVERSIZE]; // R8
            end
        end

        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                cntQ <= '0;
                errQ <= 1'b0;
            end else begin
                cntQ <= cntD;
                errQ <= errD;
            end
        end

        assign lenErr[i] = errQ;
    end

    // Short frame padding request at the last byte
    logic padQ, padD;

    always_comb begin
        padD = txLastByte && txActive && !softRst && cfgQ[`MCC_BIT_PAD_SHORT]
               && g_len[0].cntQ < 11'(`MCC_MIN_FRAME_BYTES - 1); // R5
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            padQ <= 1'b0;
        end else begin
            padQ <= padD;
        end
    end

    assign padReq = padQ;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_rsv_read_zero: assert property (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:11] == 21'h000000) // R17
        else $error("reserved bits read nonzero");
    a_fd_no_defer: assert property (ctlOut.fullDuplexSel |-> !deferTx && !colSeen) // R15
        else $error("full duplex deferred or saw collision");
    a_hd_rx_off: assert property (!fd && !lb && txActive |=> !rxEnableOut) // R16
        else $error("receive enabled during half duplex transmit");
    a_lb_rx_on: assert property (lb && !softRst |=> rxEnableOut) // R13
        else $error("loopback lost receive path");
    a_pad_forces_crc: assert property (cfgQ[`MCC_BIT_PAD_SHORT] |=> ctlOut.appendCrc) // R5
        else $error("padding without crc");
    a_mode_reserved: assert property (modeV == 2'h3 |=> !(ctlOut.selMii || ctlOut.selTpPmd || ctlOut.sel10BaseT)) // R18
        else $error("reserved mode enabled a path");
    a_cipher_tp_only: assert property (ctlOut.cipherBypass |-> ctlOut.selTpPmd) // R3
        else $error("cipher bypass outside tp-pmd");
    a_jab_blocks_tx: assert property (jabQ == mcc_pkg::JAB_BLOCK |-> !transmitEnableOut) // R9
        else $error("transmit enabled while jabber blocks");
    a_jab_abort_enter: assert property (jabberAbort |-> jabQ == mcc_pkg::JAB_BLOCK && jabCntQ == '0) // R9
        else $error("jabber abort without block entry");
    a_late_retry_cfg: assert property (lateRetryReq |-> $past(cfgQ[`MCC_BIT_LATE_RETRY]) && !lateAbort) // R7
        else $error("late retry without enable");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_jab_block: cover property (jabberAbort);
    c_lb_half: cover property (lb && !fd && txActive ##1 rxEnableOut);
    c_cfg_write: cover property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == `MCC_ADR_CFG);
    c_late_retry: cover property (lateRetryReq);

endmodule

/* mcc_map.svh */
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// Register byte offsets
`define MCC_ADR_CFG            8'h00
`define MCC_ADR_STATUS         8'h04

// Configuration register
`define MCC_CFG_RESET          16'h0000
`define MCC_BIT_CIPHER_BYPASS  0
`define MCC_BIT_FULL_DUPLEX    1
`define MCC_BIT_PAD_SHORT      2
`define MCC_BIT_APPEND_CRC     3
`define MCC_BIT_LATE_RETRY     4
`define MCC_BIT_OVERSIZE       5
`define MCC_BIT_JABBER_GUARD   6
`define MCC_BIT_FAST_HOST_CLK  7
`define MCC_BIT_MODE_LO        8
`define MCC_BIT_MODE_HI        9
`define MCC_BIT_LOOPBACK       10
`define MCC_BIT_SOFT_RESET     15

// Interface mode encodings
`define MCC_MODE_MII           2'h0
`define MCC_MODE_TP_PMD        2'h1
`define MCC_MODE_10BASE_T      2'h2

// Status register
`define MCC_ST_JAB_BLOCK       0
`define MCC_ST_JAB_RUN         1
`define MCC_ST_TX_ENABLE       2
`define MCC_ST_MODE_OK         3

// Frame lengths in bytes
`define MCC_MIN_FRAME_BYTES    64
`define MCC_MAX_FRAME_BYTES    1518

// Timing
`define MCC_CLK_NS             5
`define MCC_JABBER_ON_MS       20
`define MCC_JABBER_OFF_MS      250
`define MCC_LATE_BITS          512
`define MCC_BIT_NS_100M        10
`define MCC_BIT_NS_10M         100
`define MCC_JAB_ON_CYC         ((`MCC_JABBER_ON_MS * 1000000) / `MCC_CLK_NS)
`define MCC_JAB_OFF_CYC        ((`MCC_JABBER_OFF_MS * 1000000) / `MCC_CLK_NS)
`define MCC_LATE_FAST_CYC      ((`MCC_LATE_BITS * `MCC_BIT_NS_100M) / `MCC_CLK_NS)
`define MCC_LATE_SLOW_CYC      ((`MCC_LATE_BITS * `MCC_BIT_NS_10M) / `MCC_CLK_NS)

`endif

/* mcc_phy_model.sv */
module mcc_phy_model (
    // Clock
    input  wire logic        core_clk,
    // From the device
    input  wire logic        transmit_enable_out,
    // Test control
    input  wire logic        carrierOn,
    input  wire logic [15:0] colAfter,
    // Line state
    output logic             crsIn,
    output logic             colIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] txCnt = 16'h0000;
    // Four-cycle collision burst a set time into our own transmission
    always @(posedge core_clk) begin
        txCnt <= transmit_enable_out ? txCnt + 16'h0001 : 16'h0000;
    end
    assign crsIn = carrierOn;
    assign colIn = (colAfter != 16'h0000) && (txCnt >= colAfter) && (txCnt < colAfter + 16'h0004);
endmodule

/* mcc_pkg.sv */
package mcc_pkg;

    typedef enum logic [1:0] {
        JAB_IDLE,
        JAB_RUN,
        JAB_BLOCK
    } mcc_jab_e;

    // Decoded controls towards the datapath and physical interface
    typedef struct packed {
        logic cipherBypass;
        logic fullDuplexSel;
        logic padShortPackets;
        logic appendCrc;
        logic lateCollisionRetry;
        logic oversizePacketAllow;
        logic fastHostClock;
        logic selMii;
        logic selTpPmd;
        logic sel10BaseT;
        logic loopSerdes;
        logic loopCoder;
        logic loopMii;
        logic softResetCtl;
    } mcc_ctl_s;

endpackage

/* test_mac_config_control.sv */
module test_mac_config_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic              core_clk, arst_n, cyc, we, ack, evClr, carrierOn;
    logic [7:0]        adr;
    logic [3:0]        sel;
    logic [31:0]       wdat, rdat, rd;
    logic              txEnReq, txActive, txByteStb, txLastByte, crsIn, colIn;
    logic              rxActive, rxByteStb, colSeen;
    logic              transmit_enable_out, rxEn, deferTx, jabAbort, lateRetry, lateAbort, padReq;
    logic [1:0]        lenErr;
    logic [15:0]       colAfter;
    logic [4:0]        ev = 5'h00;
    mcc_pkg::mcc_ctl_s ctlOut;
    int                n_errors = 0;
    int                n_checks = 0;
    int                i, k;

    mcc_config #(.JAB_ON_CYC(20), .JAB_OFF_CYC(30), .LATE_FAST_CYC(10), .LATE_SLOW_CYC(40)) i_mcc_config (
        .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .txEnReq(txEnReq), .txActive(txActive), .txByteStb(txByteStb), .txLastByte(txLastByte),
        .rxActive(rxActive), .rxByteStb(rxByteStb), .crsIn(crsIn), .colIn(colIn), .ctlOut(ctlOut),
        .transmitEnableOut(transmit_enable_out), .rxEnableOut(rxEn), .deferTx(deferTx), .colSeen(colSeen),
        .jabberAbort(jabAbort), .lateRetryReq(lateRetry), .lateAbort(lateAbort), .padReq(padReq),
        .lenErr(lenErr));
    mcc_phy_model i_mcc_phy_model (.core_clk(core_clk), .transmit_enable_out(transmit_enable_out), .carrierOn(carrierOn),
        .colAfter(colAfter), .crsIn(crsIn), .colIn(colIn));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Sticky record of event pulses
    always @(posedge core_clk) begin
        ev <= evClr ? 5'h00 : ev | {padReq, lateRetry, lateAbort, jabAbort, |lenErr};
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Single classic cycle; callers only write while transmit is idle
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int t;
        t = 0;
        @(posedge core_clk);
        cyc <= 1'b1; we <= w; adr <= a; sel <= 4'h3; wdat <= {16'h0000, d};
        do begin
            @(posedge core_clk);
            t++;
        end while (ack !== 1'b1);
        chk(t, 2);
        rd = rdat;
        cyc <= 1'b0;
    endtask
    function automatic mcc_pkg::mcc_ctl_s exp_ctl(input logic [15:0] c);
        logic [1:0] m;
        m = c[9:8];
        exp_ctl = '0;
        exp_ctl.cipherBypass = c[0] && m == 2'h1;
        exp_ctl.fullDuplexSel = c[1];
        exp_ctl.padShortPackets = c[2];
        exp_ctl.appendCrc = c[3] | c[2];
        exp_ctl.lateCollisionRetry = c[4];
        exp_ctl.oversizePacketAllow = c[5];
        exp_ctl.fastHostClock = c[7] && m == 2'h0;
        exp_ctl.selMii = m == 2'h0;
        exp_ctl.selTpPmd = m == 2'h1;
        exp_ctl.sel10BaseT = m == 2'h2;
        exp_ctl.loopSerdes = c[10] && m == 2'h2;
        exp_ctl.loopCoder = c[10] && m == 2'h1;
        exp_ctl.loopMii = c[10] && m == 2'h0;
        exp_ctl.softResetCtl = c[15];
    endfunction
    task automatic cfg(input logic [15:0] c);
        wb(1'b1, 8'h00, c);
        tick(1);
        chk(32'(ctlOut), 32'(exp_ctl(c)));
        wb(1'b0, 8'h00, 16'h0000);
        chk(rd, {16'h0000, c & 16'h07ff});
    endtask
    task automatic bytes(input logic rx, input int n);
        int b;
        @(posedge core_clk);
        evClr <= 1'b1; txActive <= !rx; rxActive <= rx;
        for (b = 0; b < n; b++) begin
            @(posedge core_clk);
            evClr <= 1'b0; txByteStb <= !rx; rxByteStb <= rx; txLastByte <= !rx && (b == n - 1);
        end
        @(posedge core_clk);
        txByteStb <= 1'b0; rxByteStb <= 1'b0; txLastByte <= 1'b0; txActive <= 1'b0; rxActive <= 1'b0;
        tick(2);
    endtask
    task automatic give_verdict;
        $display("errors=%0d checks=%0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end

    initial begin
        logic [15:0] bc [8] = '{16'h0004, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0020, 16'h0000, 16'h0020};
        int          bn [8] = '{10, 64, 10, 1519, 1518, 1519, 1519, 1519};
        logic [4:0]  be [8] = '{5'h10, 5'h00, 5'h00, 5'h01, 5'h00, 5'h00, 5'h01, 5'h00};
        logic        br [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic [15:0] lc [6] = '{16'h0000, 16'h0010, 16'h0010, 16'h0002, 16'h0200, 16'h0200};
        logic [15:0] la [6] = '{16'h000f, 16'h000f, 16'h0003, 16'h000f, 16'h000f, 16'h002d};
        logic [4:0]  le [6] = '{5'h04, 5'h08, 5'h00, 5'h00, 5'h00, 5'h04};
        logic [15:0] dc [4] = '{16'h0000, 16'h0002, 16'h0400, 16'h0402};
        arst_n = 1'b0; cyc = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
        txEnReq = 1'b0; txActive = 1'b0; txByteStb = 1'b0; txLastByte = 1'b0;
        rxActive = 1'b0; rxByteStb = 1'b0;
        carrierOn = 1'b0; colAfter = 16'h0000; evClr = 1'b1;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        wb(1'b0, 8'h00, 16'h0000);
        chk(rd, 32'h0);
        chk(32'(ctlOut), 32'(exp_ctl(16'h0000)));
        for (k = 0; k < 4; k++) cfg(16'h0481 | 16'(k << 8));
        cfg(16'hffff);
        @(posedge core_clk);
        txEnReq <= 1'b1;
        tick(3);
        chk(transmit_enable_out, 0);
        chk(rxEn, 0);
        @(posedge core_clk);
        txEnReq <= 1'b0;
        cfg(16'h0000);
        for (k = 0; k < 8; k++) begin
            cfg(bc[k]);
            bytes(br[k], bn[k]);
            chk(ev, be[k]);
        end
        for (k = 0; k < 6; k++) begin
            cfg(lc[k]);
            @(posedge core_clk);
            evClr <= 1'b1; txEnReq <= 1'b1; txActive <= 1'b1; colAfter <= la[k];
            @(posedge core_clk);
            evClr <= 1'b0;
            tick(60);
            chk(ev, le[k]);
            @(posedge core_clk);
            txEnReq <= 1'b0; txActive <= 1'b0; colAfter <= 16'h0000;
        end
        for (k = 0; k < 4; k++) begin
            cfg(dc[k]);
            @(posedge core_clk);
            carrierOn <= 1'b1; txActive <= 1'b1; txEnReq <= 1'b1; colAfter <= 16'h0001;
            tick(3);
            chk(deferTx, !dc[k][1]);
            chk(colSeen, !dc[k][1]);
            chk(rxEn, dc[k] != 16'h0000);
            @(posedge core_clk);
            carrierOn <= 1'b0; txActive <= 1'b0; txEnReq <= 1'b0; colAfter <= 16'h0000;
        end
        cfg(16'h0240);
        @(posedge core_clk);
        txEnReq <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk);
            if (jabAbort === 1'b1) break;
        end
        chk(i, 20);
        wb(1'b0, 8'h04, 16'h0000);
        chk(rd, 32'h0000_0009);
        tick(2);
        chk(transmit_enable_out, 0);
        tick(30);
        chk(transmit_enable_out, 1);
        @(posedge core_clk);
        txEnReq <= 1'b0;
        cfg(16'h0200);
        @(posedge core_clk);
        txEnReq <= 1'b1; evClr <= 1'b1;
        @(posedge core_clk);
        evClr <= 1'b0;
        tick(40);
        chk(transmit_enable_out, 1);
        chk(ev, 0);
        @(posedge core_clk);
        txEnReq <= 1'b0;
        wb(1'b1, 8'h08, 16'h1234);
        wb(1'b0, 8'h08, 16'h0000);
        chk(rd, 32'h0);
        cfg(16'h07ff);
        @(posedge core_clk);
        arst_n <= 1'b0;
        tick(2);
        arst_n <= 1'b1;
        wb(1'b0, 8'h00, 16'h0000);
        chk(rd, 32'h0);
        give_verdict();
    end
endmodule
